// ==== host_port_pkg.sv ====
// Package for the octal transceiver host port: widths, register space, interrupt layout
package host_port_pkg;
   localparam int data_width = 8;
   localparam int addr_width = 13;
   localparam int reg_count = 16;
   localparam int reg_index_width = 4;
   localparam logic [7:0] reg_reset_value = 8'h00;
   // Interrupt source layout: 8 framers, 8 line interface units, 8 bit error testers
   localparam int unit_count = 8;
   localparam logic [12:0] framer_status_addr = 13'h0000;
   localparam logic [12:0] liu_status_addr = 13'h0001;
   localparam logic [12:0] bit_error_tester_status_addr = 13'h0002;
   localparam logic [12:0] framer_mask_addr = 13'h0003;
   localparam logic [12:0] liu_mask_addr = 13'h0004;
   localparam logic [12:0] bit_error_tester_mask_addr = 13'h0005;
   localparam logic [12:0] global_mask_addr = 13'h0006;
   localparam logic [12:0] pending_addr = 13'h0007;
   localparam logic [7:0] mask_reset_value = 8'hff;
   localparam logic [2:0] global_mask_reset_value = 3'h7;
   localparam logic [12:0] general_base_addr = 13'h0008;

   typedef struct packed {
      logic [7:0] framer;
      logic [7:0] line_interface_unit;
      logic [7:0] bit_error_tester;
   } irq_group_type;

   typedef struct packed {
      logic chip_select_n;
      logic read_or_data_strobe_n;
      logic write_or_rw_select_n;
      logic bus_style_select;
   } strobe_type;
endpackage : host_port_pkg

// ==== octal_transceiver_host_port.sv ====
// Octal transceiver parallel host port with register access and interrupt masking
`timescale 1ns/1ps

module octal_transceiver_host_port
   import host_port_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Host bus pins
   input wire logic [host_port_pkg::addr_width-1:0] address,
   input wire logic [host_port_pkg::data_width-1:0] data_in,
   output logic [host_port_pkg::data_width-1:0] data_out,
   output logic data_oe,
   input wire host_port_pkg::strobe_type strobes,
   // Reset and test pins
   input wire logic device_reset_n,
   input wire logic io_pin_enable,
   input wire logic test_port_reset_n,
   // Events from the units, one-cycle pulses
   input wire host_port_pkg::irq_group_type unit_events,
   // Open-drain interrupt
   output logic irq_out_n,
   output logic irq_oe,
   // Pin float control for the rest of the device
   output logic pins_enabled
);
   import host_port_pkg::*;

   // Pin synchronisers
   logic [3:0] strobe_meta, strobe_sync, next_strobe_sync;
   logic [2:0] ctl_meta, ctl_sync, next_ctl_sync;
   logic [12:0] addr_meta, addr_sync, next_addr_sync;
   logic [7:0] din_meta, din_sync, next_din_sync;

   always_comb
   begin
      next_strobe_sync = strobe_meta;
      next_ctl_sync = ctl_meta;
      next_addr_sync = addr_meta;
      next_din_sync = din_meta;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         strobe_meta <= 4'hf;
         strobe_sync <= 4'hf;
         ctl_meta <= 3'h7;
         ctl_sync <= 3'h7;
         addr_meta <= 13'h0000;
         addr_sync <= 13'h0000;
         din_meta <= 8'h00;
         din_sync <= 8'h00;
      end
      else
      begin
         strobe_meta <= strobes;
         strobe_sync <= next_strobe_sync;
         ctl_meta <= {device_reset_n, io_pin_enable, test_port_reset_n};
         ctl_sync <= next_ctl_sync;
         addr_meta <= address;
         addr_sync <= next_addr_sync;
         din_meta <= data_in;
         din_sync <= next_din_sync;
      end
   end

   logic cs_n;
   logic rd_pin_n;
   logic wr_pin_n;
   logic style_hi;
   logic dev_rst_n;
   logic read_active;
   logic write_active;
   logic write_prev;
   logic write_strobe;
   assign cs_n = strobe_sync[3];
   assign rd_pin_n = strobe_sync[2];
   assign wr_pin_n = strobe_sync[1];
   assign style_hi = strobe_sync[0];
   assign dev_rst_n = ctl_sync[2];

   // Style high: data strobe low frames the access, read/write line high means read
   always_comb
   begin
      if (style_hi)
      begin
         read_active = !cs_n && !rd_pin_n && wr_pin_n;
         write_active = !cs_n && !rd_pin_n && !wr_pin_n;
      end
      else
      begin
         read_active = !cs_n && !rd_pin_n;
         write_active = !cs_n && !wr_pin_n;
      end
   end

   // Commit at strobe end; chip select held low through it
   assign write_strobe = write_prev && !write_active && !cs_n;

   // Register state
   logic [7:0] regs [reg_count];
   logic [7:0] framer_mask;
   logic [7:0] liu_mask;
   logic [7:0] bit_error_tester_mask;
   logic [2:0] global_mask;
   irq_group_type pending;
   irq_group_type next_pending;
   logic [7:0] next_framer_mask;
   logic [7:0] next_liu_mask;
   logic [7:0] next_bit_error_tester_mask;
   logic [2:0] next_global_mask;
   logic [7:0] read_value;
   logic [7:0] next_data_out;
   logic [2:0] group_pending;
   logic any_irq;

   always_comb
   begin
      next_framer_mask = framer_mask;
      next_liu_mask = liu_mask;
      next_bit_error_tester_mask = bit_error_tester_mask;
      next_global_mask = global_mask;
      next_pending = pending;
      if (write_strobe)
      begin
         case (addr_sync)
            framer_status_addr: next_pending.framer = pending.framer & ~din_sync;
            liu_status_addr: next_pending.line_interface_unit =
               pending.line_interface_unit & ~din_sync;
            bit_error_tester_status_addr: next_pending.bit_error_tester =
               pending.bit_error_tester & ~din_sync;
            framer_mask_addr: next_framer_mask = din_sync;
            liu_mask_addr: next_liu_mask = din_sync;
            bit_error_tester_mask_addr: next_bit_error_tester_mask = din_sync;
            global_mask_addr: next_global_mask = din_sync[2:0];
            default: next_pending = next_pending;
         endcase
      end
      // A fresh event outranks an acknowledge in the same cycle
      next_pending = next_pending | unit_events;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         framer_mask <= mask_reset_value;
         liu_mask <= mask_reset_value;
         bit_error_tester_mask <= mask_reset_value;
         global_mask <= global_mask_reset_value;
         pending <= '0;
         write_prev <= 1'b0;
      end
      else if (!dev_rst_n)
      begin
         framer_mask <= mask_reset_value;
         liu_mask <= mask_reset_value;
         bit_error_tester_mask <= mask_reset_value;
         global_mask <= global_mask_reset_value;
         pending <= '0;
         write_prev <= 1'b0;
      end
      else
      begin
         framer_mask <= next_framer_mask;
         liu_mask <= next_liu_mask;
         bit_error_tester_mask <= next_bit_error_tester_mask;
         global_mask <= next_global_mask;
         pending <= next_pending;
         write_prev <= write_active;
      end
   end

   // General-purpose register array, one entry per generate index
   genvar g;
   generate
      for (g = 0; g < reg_count; g++)
      begin : gen_regs
         logic hit;
         logic [7:0] next_value;
         assign hit = write_strobe &&
            (addr_sync == general_base_addr + 13'(g));
         always_comb
         begin
            next_value = hit ? din_sync : regs[g];
         end
         always_ff @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
               regs[g] <= reg_reset_value;
            else if (!dev_rst_n)
               regs[g] <= reg_reset_value;
            else
               regs[g] <= next_value;
         end
      end
   endgenerate

   // Mask bit set means the source is blocked
   assign group_pending[0] = |(pending.framer & ~framer_mask) && !global_mask[0];
   assign group_pending[1] = |(pending.line_interface_unit & ~liu_mask) && !global_mask[1];
   assign group_pending[2] = |(pending.bit_error_tester & ~bit_error_tester_mask) && !global_mask[2];
   assign any_irq = |group_pending;

   always_comb
   begin
      read_value = 8'h00;
      case (addr_sync)
         framer_status_addr: read_value = pending.framer;
         liu_status_addr: read_value = pending.line_interface_unit;
         bit_error_tester_status_addr: read_value = pending.bit_error_tester;
         framer_mask_addr: read_value = framer_mask;
         liu_mask_addr: read_value = liu_mask;
         bit_error_tester_mask_addr: read_value = bit_error_tester_mask;
         global_mask_addr: read_value = {5'h00, global_mask};
         pending_addr: read_value = {5'h00, group_pending};
         default:
         begin
            if (addr_sync >= general_base_addr &&
                addr_sync < general_base_addr + 13'(reg_count))
               read_value = regs[reg_index_width'(addr_sync - general_base_addr)];
         end
      endcase
      next_data_out = read_value;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         data_out <= 8'h00;
      else
         data_out <= next_data_out;
   end

   // Float all pins only when both test inputs are low
   assign pins_enabled = ctl_sync[1] || ctl_sync[0];
   assign data_oe = read_active && pins_enabled && dev_rst_n;
   assign irq_out_n = 1'b0;
   assign irq_oe = any_irq && pins_enabled && dev_rst_n;

   default clocking main_edge @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_read_drives_bus: assert property (
      (read_active && pins_enabled && dev_rst_n) |-> data_oe)
      else $error("Qualified read left bus undriven");
   a_read_data_value: assert property (
      (data_oe && addr_sync == framer_mask_addr && $stable(addr_sync) && $stable(framer_mask))
      |-> data_out == framer_mask)
      else $error("Read data differs from addressed register");
   a_bus_idle_float: assert property (!read_active |-> !data_oe)
      else $error("Bus driven outside a read");
   a_cs_gates_strobes: assert property (cs_n |-> (!data_oe && !write_strobe))
      else $error("Strobe acted with chip select high");
   a_write_stores_mask: assert property (
      (write_strobe && addr_sync == framer_mask_addr && dev_rst_n)
      |=> framer_mask == $past(din_sync))
      else $error("Write did not store data");
   a_event_raises_irq: assert property (
      (unit_events.framer[0] && !framer_mask[0] && !global_mask[0] && dev_rst_n
       && !write_strobe && $stable(framer_mask) && pins_enabled)
      |=> (irq_oe || !pins_enabled || !dev_rst_n))
      else $error("Unmasked event did not raise interrupt");
   a_irq_needs_pending: assert property (irq_oe |-> (group_pending != 3'h0))
      else $error("Interrupt with nothing pending");
   a_mask_blocks: assert property ((global_mask == 3'h7) |-> !irq_oe)
      else $error("Masked source asserted interrupt");
   a_style_write: assert property (
      (style_hi && !cs_n && !rd_pin_n && wr_pin_n) |-> !write_active)
      else $error("Read cycle seen as write in strobe style");
   a_device_reset: assert property (
      !dev_rst_n |=> (pending == '0 && global_mask == global_mask_reset_value))
      else $error("Device reset did not clear state");
   a_pins_float: assert property (
      (ctl_sync[1:0] == 2'h0) |-> (!data_oe && !irq_oe && !pins_enabled))
      else $error("Pins driven while floated");

   c_read_access: cover property (data_oe);
   c_write_access: cover property (write_strobe);
   c_irq_raised: cover property (irq_oe);
   c_irq_cleared: cover property ($fell(irq_oe) && dev_rst_n);
endmodule : octal_transceiver_host_port

// ==== host_bus_model.sv ====
// Host processor model that drives the parallel register pins
`timescale 1ns/1ps
module host_bus_model
   import host_port_pkg::*;
(
   // Clock
   input wire logic clock,
   // Device side of the data bus
   input wire logic [host_port_pkg::data_width-1:0] data_out,
   input wire logic data_oe,
   // Host pins
   output logic [host_port_pkg::addr_width-1:0] address,
   output logic [host_port_pkg::data_width-1:0] data_in,
   output host_port_pkg::strobe_type strobes
);
   import host_port_pkg::*;
   logic drive;
   logic [7:0] wdata;
   logic [7:0] last;
   // A released bus toggles every cycle so a stale value can never pass
   always_comb data_in = data_oe ? data_out : (drive ? wdata : ~last);
   always @(posedge clock) last <= data_in;
   initial
   begin
      drive = 1'b0;
      wdata = 8'h00;
      last = 8'h00;
      address = 13'h0000;
      strobes = 4'hf;
   end
   task automatic access(input logic sty, input logic cs_n, input logic wr,
      input logic [12:0] addr, input logic [7:0] d, output logic [7:0] q, output logic oe);
      @(negedge clock);
      strobes.bus_style_select = sty;
      @(negedge clock);
      address = addr;
      wdata = d;
      drive = wr;
      strobes.chip_select_n = cs_n;
      strobes.write_or_rw_select_n = ~wr;
      strobes.read_or_data_strobe_n = sty ? 1'b0 : wr;
      repeat (5) @(negedge clock);
      q = data_out;
      oe = data_oe;
      // Strobe rises first; select, address and data stay three more cycles
      strobes.read_or_data_strobe_n = 1'b1;
      if (!sty) strobes.write_or_rw_select_n = 1'b1;
      repeat (3) @(negedge clock);
      strobes.chip_select_n = 1'b1;
      strobes.write_or_rw_select_n = 1'b1;
      drive = 1'b0;
      repeat (2) @(negedge clock);
   endtask : access
endmodule : host_bus_model

// ==== tb_octal_transceiver_host_port.sv ====
// Self-checking bench for the octal transceiver host port
`timescale 1ns/1ps
module tb_octal_transceiver_host_port;
   import host_port_pkg::*;
   typedef struct packed {
      logic sty;
      logic wr;
      logic [12:0] addr;
      logic [7:0] d;
      logic [7:0] exp;
   } row_type;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [12:0] address;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic data_oe;
   strobe_type strobes;
   logic device_reset_n = 1'b1;
   logic io_pin_enable = 1'b1;
   logic test_port_reset_n = 1'b1;
   irq_group_type unit_events = '0;
   logic irq_out_n;
   logic irq_oe;
   logic pins_enabled;
   logic [7:0] q;
   logic oe;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   row_type rows [8] = '{
      '{1'b0, 1'b1, 13'h0008, 8'ha5, 8'ha5},
      '{1'b0, 1'b0, 13'h0008, 8'h00, 8'ha5},
      '{1'b1, 1'b1, 13'h0017, 8'h3c, 8'h3c},
      '{1'b1, 1'b0, 13'h0017, 8'h00, 8'h3c},
      '{1'b0, 1'b1, 13'h0018, 8'h77, 8'h00},
      '{1'b0, 1'b0, 13'h0018, 8'h00, 8'h00},
      '{1'b1, 1'b0, 13'h1008, 8'h00, 8'h00},
      '{1'b0, 1'b0, 13'h0009, 8'h00, 8'h00}};
   octal_transceiver_host_port DUT (.clock(clock), .reset_n(reset_n), .address(address),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .strobes(strobes),
      .device_reset_n(device_reset_n), .io_pin_enable(io_pin_enable),
      .test_port_reset_n(test_port_reset_n), .unit_events(unit_events),
      .irq_out_n(irq_out_n), .irq_oe(irq_oe), .pins_enabled(pins_enabled));
   host_bus_model host (.clock(clock), .data_out(data_out), .data_oe(data_oe),
      .address(address), .data_in(data_in), .strobes(strobes));
   initial
   begin
      forever #50 clock = ~clock;
   end
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   // Cut a hang short well past the few hundred cycles the tests need
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask : check_bit
   task automatic acc(input logic s, input logic w, input logic [12:0] a, input logic [7:0] d);
      host.access(s, 1'b0, w, a, d, q, oe);
   endtask : acc
   task automatic pulse(input irq_group_type ev);
      @(negedge clock);
      unit_events = ev;
      @(negedge clock);
      unit_events = '0;
      repeat (2) @(negedge clock);
   endtask : pulse
   initial
   begin
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      repeat (3) @(negedge clock);
      check_bit(data_oe, 1'b0);
      foreach (rows[i])
      begin
         acc(rows[i].sty, rows[i].wr, rows[i].addr, rows[i].d);
         check_bit(oe, ~rows[i].wr);
         if (!rows[i].wr) check_byte(q, rows[i].exp);
      end
      $display("test table done");
      host.access(1'b0, 1'b1, 1'b1, 13'h0009, 8'h5a, q, oe);
      host.access(1'b0, 1'b1, 1'b0, 13'h0008, 8'h00, q, oe);
      check_bit(oe, 1'b0);
      acc(1'b0, 1'b0, 13'h0009, 8'h00);
      check_byte(q, 8'h00);
      for (int a = 3; a < 8; a++)
      begin
         acc(1'b0, 1'b0, a[12:0], 8'h00);
         check_byte(q, a < 6 ? 8'hff : (a == 6 ? 8'h07 : 8'h00));
      end
      $display("test select and reset values done");
      acc(1'b0, 1'b1, framer_mask_addr, 8'hfc);
      acc(1'b1, 1'b1, global_mask_addr, 8'h06);
      pulse(24'h030000);
      check_bit(irq_oe, 1'b1);
      check_bit(irq_out_n, 1'b0);
      acc(1'b0, 1'b1, framer_status_addr, 8'h01);
      check_bit(irq_oe, 1'b1);
      acc(1'b0, 1'b1, framer_status_addr, 8'h02);
      check_bit(irq_oe, 1'b0);
      pulse(24'h000400);
      check_bit(irq_oe, 1'b0);
      acc(1'b0, 1'b0, liu_status_addr, 8'h00);
      check_byte(q, 8'h04);
      acc(1'b0, 1'b1, liu_mask_addr, 8'h00);
      check_bit(irq_oe, 1'b0);
      acc(1'b0, 1'b1, global_mask_addr, 8'h04);
      check_bit(irq_oe, 1'b1);
      acc(1'b0, 1'b1, liu_status_addr, 8'h04);
      check_bit(irq_oe, 1'b0);
      $display("test interrupt done");
      io_pin_enable = 1'b0;
      test_port_reset_n = 1'b0;
      repeat (4) @(negedge clock);
      check_bit(pins_enabled, 1'b0);
      io_pin_enable = 1'b1;
      repeat (4) @(negedge clock);
      check_bit(pins_enabled, 1'b1);
      test_port_reset_n = 1'b1;
      $display("test pin float done");
      device_reset_n = 1'b0;
      repeat (4) @(negedge clock);
      device_reset_n = 1'b1;
      repeat (4) @(negedge clock);
      acc(1'b0, 1'b0, 13'h0008, 8'h00);
      check_byte(q, 8'h00);
      acc(1'b1, 1'b0, liu_mask_addr, 8'h00);
      check_byte(q, 8'hff);
      $display("test device reset done");
      tally_and_finish();
   end
endmodule : tb_octal_transceiver_host_port
